// >>> hdl/aad_pkg.sv
// Purpose: Shared constants and carriers for the adjust/add decode-execute block
// Assumes: Byte-serial instruction stream, one byte per handshake
// Notes:   Flag vector order is {overflow, sign, zero, auxiliary, parity, carry}
package aad_pkg;
    localparam logic [7:0] OP_ADJ_SUM     = 8'h37;
    localparam logic [7:0] OP_ADJ_SUB     = 8'h3F;
    localparam logic [7:0] OP_ADJ_DIV     = 8'hD5;
    localparam logic [7:0] OP_ADJ_MUL     = 8'hD4;
    localparam logic [7:0] OP_ADJ_BASE    = 8'h0A;
    localparam logic [3:0] HI_ADD         = 4'h0;
    localparam logic [3:0] HI_ADC         = 4'h1;
    localparam logic [3:0] HI_IMM_GRP     = 4'h8;
    localparam logic [2:0] REG_ADC        = 3'h2;
    localparam logic [2:0] REG_ADD        = 3'h0;
    localparam logic [1:0] MOD_REG        = 2'h3;
    localparam logic [1:0] MOD_NODISP     = 2'h0;
    localparam logic [1:0] MOD_DISP8      = 2'h1;
    localparam logic [3:0] CYC_ADJ_SUM    = 4'h3;
    localparam logic [4:0] CYC_ADJ_DIV    = 5'h07;
    localparam logic [4:0] CYC_ADJ_MUL    = 5'h13;
    localparam logic [4:0] CYC_SIMPLE     = 5'h01;
    localparam int         FLG_OF = 5;
    localparam int         FLG_SF = 4;
    localparam int         FLG_ZF = 3;
    localparam int         FLG_AF = 2;
    localparam int         FLG_PF = 1;
    localparam int         FLG_CF = 0;
    localparam logic [5:0] FLAGS_RESET    = 6'h00;

    typedef enum logic [3:0] {
        AAD_OP_NONE, AAD_OP_SUM, AAD_OP_SUB, AAD_OP_DIV, AAD_OP_MUL, AAD_OP_ADD, AAD_OP_ADC
    } aad_op_t;

    typedef struct packed {
        aad_op_t     op;
        logic        dir;        // Register field is destination
        logic        wide;       // Full operand width
        logic        imm;
        logic        mem;
        logic        acc;
        logic [1:0]  mode;
        logic [2:0]  reg_f;
        logic [2:0]  rm_f;
        logic [31:0] disp;
        logic [31:0] immv;
        logic [4:0]  cycles;
        logic [5:0]  fl_mask;    // Flags written by the instruction
        logic [5:0]  fl_undef;   // Flags left undefined
    } aad_dec_t;
endpackage

// >>> hdl/aad_core.sv
// Purpose: Decode ASCII-adjust and add/add-with-carry, execute register forms
// Assumes: Bytes arrive synchronous to clk_in; memory operands resolved outside
// Notes:   Control flags (direction, interrupt, trap) are never touched here
`timescale 1ns/100ps

// Function
// - Opcode 37: adjust after sum, sets aux/carry, 3 clocks.
// - D5 0A: adjust before divide, sets sign/zero/parity, 7 clocks.
// - D4 0A: adjust after multiply, same flags, 19 clocks.
// - Opcode 3F: adjust after subtract, sets aux/carry, 3 clocks.
// - Add-with-carry register to register, all six flags, 1 clock.
// - Add-with-carry into memory, 000w plus ModR/M, 1 clock on hit.
// - Add-with-carry from memory into register, 001w, 1 clock on hit.
// - Immediate add-with-carry, group 8 reg 010 or accumulator 010w, 1 clock.
// - Add register to register, all six flags, 1 clock.
// - Add into memory, 000w plus ModR/M, 1 clock on hit.
// - Add from memory into register, 001w, 1 clock on hit.
// - Immediates are one byte, two bytes or full operand width.
// - Displacement is signed byte or full 16/32 bits, short one sign-extended.
module aad_core (
    input  wire logic               clk_in,
    input  wire logic               reset_n_in,
    input  wire logic               byte_valid_in,
    input  wire logic [7:0]         byte_in,
    input  wire logic               opsize32_in,
    input  wire logic               addrsize32_in,
    input  wire logic [31:0]        acc_in,
    input  wire logic [31:0]        reg_a_in,
    input  wire logic [31:0]        reg_b_in,
    input  wire logic [5:0]         flags_in,
    output logic                    byte_ready_out,
    output logic                    done_out,
    output logic                    illegal_out,
    output aad_pkg::aad_dec_t       dec_out,
    output logic [31:0]             result_out,
    output logic [5:0]              flags_out
);
    typedef enum logic [2:0] {S_OP, S_SECOND, S_MODRM, S_DISP, S_IMM, S_EXEC} aad_state_t;

    aad_state_t        state;
    aad_pkg::aad_dec_t dec;
    logic [2:0]        need;
    logic [2:0]        got;
    logic [4:0]        cnt;
    logic [31:0]       res;
    logic [5:0]        flg;
    logic              imm_short;
    logic              take;

    assign take = byte_valid_in && byte_ready_out;

    function automatic logic parity8(input logic [7:0] v);
        return ~^v;
    endfunction

    // Bytes of displacement for the ModR/M mode at the current address size
    function automatic logic [2:0] disp_len(input logic [1:0] m, input logic [2:0] rm, input logic a32);
        if (m == aad_pkg::MOD_DISP8)
            return 3'h1;
        if (m == 2'h2 || (m == aad_pkg::MOD_NODISP && rm == (a32 ? 3'h5 : 3'h6)))
            return a32 ? 3'h4 : 3'h2;
        return 3'h0;
    endfunction

    function automatic logic [2:0] imm_len(input logic wide, input logic sx, input logic o32);
        if (!wide || sx)
            return 3'h1;
        return o32 ? 3'h4 : 3'h2;
    endfunction

    // Opcode fetch and field capture
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state       <= S_OP;
            dec         <= '0;
            need        <= 3'h0;
            got         <= 3'h0;
            imm_short   <= 1'b0;
            illegal_out <= 1'b0;
        end else begin
            illegal_out <= 1'b0;
            case (state)
                S_OP: if (take) begin
                    dec          <= '0;
                    dec.wide     <= byte_in[0];
                    dec.dir      <= byte_in[1];
                    dec.fl_mask  <= 6'h3F;
                    dec.cycles   <= aad_pkg::CYC_SIMPLE;
                    got          <= 3'h0;
                    imm_short    <= 1'b0;
                    if (byte_in == aad_pkg::OP_ADJ_SUM || byte_in == aad_pkg::OP_ADJ_SUB) begin
                        dec.op       <= (byte_in == aad_pkg::OP_ADJ_SUM) ? aad_pkg::AAD_OP_SUM : aad_pkg::AAD_OP_SUB;
                        dec.cycles   <= {1'b0, aad_pkg::CYC_ADJ_SUM};
                        dec.fl_mask  <= 6'h05;
                        dec.fl_undef <= 6'h3A;
                        state        <= S_EXEC;
                    end else if (byte_in == aad_pkg::OP_ADJ_DIV || byte_in == aad_pkg::OP_ADJ_MUL) begin
                        dec.op       <= (byte_in == aad_pkg::OP_ADJ_DIV) ? aad_pkg::AAD_OP_DIV : aad_pkg::AAD_OP_MUL;
                        dec.cycles   <= (byte_in == aad_pkg::OP_ADJ_DIV) ? aad_pkg::CYC_ADJ_DIV
                                                                         : aad_pkg::CYC_ADJ_MUL;
                        dec.fl_mask  <= 6'h1A;
                        dec.fl_undef <= 6'h25;
                        state        <= S_SECOND;
                    end else if ((byte_in[7:4] == aad_pkg::HI_ADD || byte_in[7:4] == aad_pkg::HI_ADC)
                                 && byte_in[3:2] == 2'h0) begin
                        dec.op <= (byte_in[4]) ? aad_pkg::AAD_OP_ADC : aad_pkg::AAD_OP_ADD;
                        state  <= S_MODRM;
                    end else if ((byte_in[7:4] == aad_pkg::HI_ADD || byte_in[7:4] == aad_pkg::HI_ADC)
                                 && byte_in[3:1] == 3'h2) begin
                        dec.op  <= (byte_in[4]) ? aad_pkg::AAD_OP_ADC : aad_pkg::AAD_OP_ADD;
                        dec.acc <= 1'b1;
                        dec.imm <= 1'b1;
                        dec.dir <= 1'b1;
                        need    <= imm_len(byte_in[0], 1'b0, opsize32_in);
                        state   <= S_IMM;
                    end else if (byte_in[7:4] == aad_pkg::HI_IMM_GRP && byte_in[3:2] == 2'h0) begin
                        dec.imm   <= 1'b1;
                        dec.dir   <= 1'b0;
                        imm_short <= byte_in[1];
                        state     <= S_MODRM;
                    end else begin
                        illegal_out <= 1'b1;
                    end
                end
                S_SECOND: if (take) begin
                    state <= (byte_in == aad_pkg::OP_ADJ_BASE) ? S_EXEC : S_OP;
                    illegal_out <= (byte_in != aad_pkg::OP_ADJ_BASE);
                end
                S_MODRM: if (take) begin
                    dec.mode  <= byte_in[7:6];
                    dec.reg_f <= byte_in[5:3];
                    dec.rm_f  <= byte_in[2:0];
                    dec.mem   <= (byte_in[7:6] != aad_pkg::MOD_REG);
                    got       <= 3'h0;
                    if (dec.imm && byte_in[5:3] == aad_pkg::REG_ADC)
                        dec.op <= aad_pkg::AAD_OP_ADC;
                    else if (dec.imm && byte_in[5:3] == aad_pkg::REG_ADD)
                        dec.op <= aad_pkg::AAD_OP_ADD;
                    if (dec.imm && byte_in[5:3] != aad_pkg::REG_ADC && byte_in[5:3] != aad_pkg::REG_ADD) begin
                        illegal_out <= 1'b1;
                        state       <= S_OP;
                    end else if (disp_len(byte_in[7:6], byte_in[2:0], addrsize32_in) != 3'h0) begin
                        need  <= disp_len(byte_in[7:6], byte_in[2:0], addrsize32_in);
                        state <= S_DISP;
                    end else if (dec.imm) begin
                        need  <= imm_len(dec.wide, imm_short, opsize32_in);
                        state <= S_IMM;
                    end else begin
                        state <= S_EXEC;
                    end
                end
                S_DISP: if (take) begin
                    dec.disp[8*got +: 8] <= byte_in;
                    if (need == 3'h1)
                        dec.disp <= {{24{byte_in[7]}}, byte_in};
                    else if (need == 3'h2 && got == 3'h1)
                        dec.disp[31:8] <= {{16{byte_in[7]}}, byte_in};
                    got <= got + 3'h1;
                    if (got + 3'h1 == need) begin
                        got   <= 3'h0;
                        need  <= imm_len(dec.wide, imm_short, opsize32_in);
                        state <= dec.imm ? S_IMM : S_EXEC;
                    end
                end
                S_IMM: if (take) begin
                    dec.immv[8*got +: 8] <= byte_in;
                    if (need == 3'h1)
                        dec.immv <= imm_short ? {{24{byte_in[7]}}, byte_in} : {24'h000000, byte_in};
                    got <= got + 3'h1;
                    if (got + 3'h1 == need)
                        state <= S_EXEC;
                end
                S_EXEC: if (cnt == 5'h01)
                    state <= S_OP;
                default: state <= S_OP;
            endcase
        end
    end

    // Execution countdown sets the documented clock count
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            cnt <= 5'h00;
        else if (state == S_OP && take)
            // Single-byte adjusts enter execution before dec.cycles has settled
            cnt <= {1'b0, aad_pkg::CYC_ADJ_SUM};
        else if (state != S_EXEC)
            cnt <= dec.cycles;
        else if (cnt != 5'h00)
            cnt <= cnt - 5'h01;
    end

    // Arithmetic; memory forms use reg_b_in as the fetched operand
    always_comb begin
        logic [32:0] sum;
        logic [31:0] a;
        logic [31:0] b;
        logic [7:0]  al;
        logic [15:0] ax;
        logic        cin;
        sum = '0;
        a   = dec.acc ? acc_in : (dec.dir ? reg_a_in : reg_b_in);
        b   = dec.imm ? dec.immv : (dec.dir ? reg_b_in : reg_a_in);
        al  = acc_in[7:0];
        ax  = acc_in[15:0];
        cin = (dec.op == aad_pkg::AAD_OP_ADC) ? flags_in[aad_pkg::FLG_CF] : 1'b0;
        res = acc_in;
        flg = flags_in;
        case (dec.op)
            aad_pkg::AAD_OP_SUM, aad_pkg::AAD_OP_SUB: begin
                if (al[3:0] > 4'h9 || flags_in[aad_pkg::FLG_AF]) begin
                    ax = (dec.op == aad_pkg::AAD_OP_SUM) ? ax + 16'h0106 : ax - 16'h0106;
                    flg[aad_pkg::FLG_AF] = 1'b1;
                    flg[aad_pkg::FLG_CF] = 1'b1;
                end else begin
                    flg[aad_pkg::FLG_AF] = 1'b0;
                    flg[aad_pkg::FLG_CF] = 1'b0;
                end
                res = {acc_in[31:16], ax[15:8], 4'h0, ax[3:0]};
            end
            aad_pkg::AAD_OP_DIV, aad_pkg::AAD_OP_MUL: begin
                if (dec.op == aad_pkg::AAD_OP_DIV)
                    al = 8'((16'(ax[15:8]) * 16'h000A) + 16'(ax[7:0]));
                else
                    al = ax[7:0] % 8'h0A;
                res = {acc_in[31:16], (dec.op == aad_pkg::AAD_OP_MUL) ? (ax[7:0] / 8'h0A) : 8'h00, al};
                flg[aad_pkg::FLG_SF] = al[7];
                flg[aad_pkg::FLG_ZF] = (al == 8'h00);
                flg[aad_pkg::FLG_PF] = parity8(al);
            end
            aad_pkg::AAD_OP_ADD, aad_pkg::AAD_OP_ADC: begin
                if (dec.wide && opsize32_in) begin
                    sum = {1'b0, a} + {1'b0, b} + 33'(cin);
                    res = sum[31:0];
                    flg[aad_pkg::FLG_OF] = (a[31] == b[31]) && (res[31] != a[31]);
                    flg[aad_pkg::FLG_SF] = res[31];
                end else if (dec.wide) begin
                    sum = 33'({1'b0, a[15:0]} + {1'b0, b[15:0]} + 17'(cin));
                    res = {a[31:16], sum[15:0]};
                    sum[32] = sum[16];
                    flg[aad_pkg::FLG_OF] = (a[15] == b[15]) && (res[15] != a[15]);
                    flg[aad_pkg::FLG_SF] = res[15];
                end else begin
                    sum = 33'({1'b0, a[7:0]} + {1'b0, b[7:0]} + 9'(cin));
                    res = {a[31:8], sum[7:0]};
                    sum[32] = sum[8];
                    flg[aad_pkg::FLG_OF] = (a[7] == b[7]) && (res[7] != a[7]);
                    flg[aad_pkg::FLG_SF] = res[7];
                end
                flg[aad_pkg::FLG_CF] = sum[32];
                flg[aad_pkg::FLG_ZF] = dec.wide ? (opsize32_in ? res == 32'h0 : res[15:0] == 16'h0) : res[7:0] == 8'h0;
                flg[aad_pkg::FLG_AF] = a[4] ^ b[4] ^ res[4];
                flg[aad_pkg::FLG_PF] = parity8(res[7:0]);
            end
            default: ;
        endcase
    end

    // Results published on the last execution clock
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            done_out       <= 1'b0;
            dec_out        <= '0;
            result_out     <= 32'h0000_0000;
            flags_out      <= aad_pkg::FLAGS_RESET;
            byte_ready_out <= 1'b0;
        end else begin
            done_out       <= (state == S_EXEC) && (cnt == 5'h01);
            // Drop after every taken byte so ready never stands high into execution
            byte_ready_out <= (state != S_EXEC) && !take;
            if (state == S_EXEC && cnt == 5'h01) begin
                dec_out    <= dec;
                result_out <= res;
                // Undefined flags keep prior value; control flags never leave the core
                flags_out  <= (flg & dec.fl_mask) | (flags_in & ~dec.fl_mask);
            end
        end
    end
endmodule // aad_core

// >>> bench/aad_core_checker.sv
// Purpose: Port assertions for the adjust/add decode-execute block
// Assumes: One clock, asynchronous active-low reset
// Notes:   Byte phase is tracked from the handshake plus the done and refusal pulses
`timescale 1ns/100ps
module aad_core_checker (
    input  wire logic              clk_in,
    input  wire logic              reset_n_in,
    input  wire logic              byte_valid_in,
    input  wire logic [7:0]        byte_in,
    input  wire logic              byte_ready_out,
    input  wire logic              done_out,
    input  wire logic              illegal_out,
    input  wire aad_pkg::aad_dec_t dec_out,
    input  wire logic [31:0]       result_out,
    input  wire logic [5:0]        flags_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);
    logic       op_q, after_op, take, exp_op;
    logic [7:0] last_op;
    assign take = byte_valid_in && byte_ready_out;
    // Done or refusal frees the next byte to be an opcode
    assign exp_op = op_q || done_out || illegal_out;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            op_q <= 1'h1;
            after_op <= 1'h0;
            last_op <= 8'h00;
        end else if (take) begin
            op_q <= 1'h0;
            after_op <= exp_op;
            if (exp_op) last_op <= byte_in;
        end else if (done_out || illegal_out) begin
            op_q <= 1'h1;
            after_op <= 1'h0;
        end
    end
    a_done_one_cycle: assert property (done_out |=> !done_out) else $error("done too long");
    a_sum_three: assert property (exp_op && take && byte_in == aad_pkg::OP_ADJ_SUM
        |=> (!done_out && !byte_ready_out) [*3] ##1 done_out) else $error("sum adjust timing");
    a_sub_three: assert property (exp_op && take && byte_in == aad_pkg::OP_ADJ_SUB
        |=> (!done_out && !byte_ready_out) [*3] ##1 done_out) else $error("sub adjust timing");
    a_div_seven: assert property (after_op && last_op == aad_pkg::OP_ADJ_DIV && take
        && byte_in == aad_pkg::OP_ADJ_BASE |=> !done_out [*7] ##1 done_out) else $error("div adjust timing");
    a_mul_nineteen: assert property (after_op && last_op == aad_pkg::OP_ADJ_MUL && take
        && byte_in == aad_pkg::OP_ADJ_BASE |-> ##20 done_out) else $error("mul adjust timing");
    a_regreg_one: assert property (after_op && last_op[7:5] == 3'h0 && last_op[3:2] == 2'h0
        && take && byte_in[7:6] == aad_pkg::MOD_REG |-> ##2 done_out) else $error("reg add timing");
    a_bad_second: assert property (after_op && last_op == aad_pkg::OP_ADJ_DIV && take
        && byte_in != aad_pkg::OP_ADJ_BASE |-> ##[1:2] illegal_out) else $error("bad second byte kept");
    a_result_hold: assert property (!done_out |-> $stable(result_out) && $stable(flags_out))
        else $error("result moved without done");
    c_adc_done: cover property (done_out && dec_out.op == aad_pkg::AAD_OP_ADC);
    c_mem_done: cover property (done_out && dec_out.mem);
    c_refused: cover property (illegal_out);
endmodule // aad_core_checker

bind aad_core aad_core_checker i_chk (.clk_in(clk_in), .reset_n_in(reset_n_in), .byte_valid_in(byte_valid_in),
    .byte_in(byte_in), .byte_ready_out(byte_ready_out), .done_out(done_out), .illegal_out(illegal_out),
    .dec_out(dec_out), .result_out(result_out), .flags_out(flags_out));

// >>> bench/aad_core_tb.sv
// Purpose: Self-checking bench for the adjust/add decode-execute block
// Assumes: Inputs move 1 ns after the rising edge
// Notes:   Memory forms use r/m 001 so no index byte follows
`timescale 1ns/100ps
module aad_core_tb;
    logic              clk_in, reset_n_in, byte_valid_in, opsize32_in, addrsize32_in;
    logic              byte_ready_out, done_out, illegal_out, adc, d, w, s, g, ill;
    logic [7:0]        byte_in, q[$];
    logic [31:0]       acc_in, reg_a_in, reg_b_in, result_out, v, m;
    logic [5:0]        flags_in, flags_out;
    logic [37:0]       ex;
    logic [21:0]       ea;
    aad_pkg::aad_dec_t dec_out;
    logic [7:0]        ops[4] = '{aad_pkg::OP_ADJ_SUM, aad_pkg::OP_ADJ_DIV, aad_pkg::OP_ADJ_MUL, aad_pkg::OP_ADJ_SUB};
    logic [15:0]       bad[3] = '{16'h9000, 16'hD50B, 16'h80C8};
    int                lats[4] = '{3, 7, 19, 3};
    int                fails = 0, cmp_count = 0, cycles = 0, seed = 32'hCBE93A96, k, wd, n;
    aad_core i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .byte_valid_in(byte_valid_in), .byte_in(byte_in),
        .opsize32_in(opsize32_in), .addrsize32_in(addrsize32_in), .acc_in(acc_in), .reg_a_in(reg_a_in),
        .reg_b_in(reg_b_in), .flags_in(flags_in), .byte_ready_out(byte_ready_out), .done_out(done_out),
        .illegal_out(illegal_out), .dec_out(dec_out), .result_out(result_out), .flags_out(flags_out));
    initial begin
        clk_in = 1'h0;
        forever #4 clk_in = ~clk_in;
    end
    task automatic final_report();
        $display("Compares %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            final_report();
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic send(input logic [7:0] b);
        int t;
        t = 0;
        byte_valid_in = 1'h1;
        byte_in = b;
        do begin
            @(negedge clk_in);
            t++;
        end while (byte_ready_out !== 1'h1 && t < 50);
        @(posedge clk_in);
        #1;
    endtask
    // Counts edges from the last taken byte to done or refusal
    task automatic run();
        foreach (q[i]) send(q[i]);
        byte_valid_in = 1'h0;
        // Refusal pulse stands only in the cycle after the last byte
        ill = illegal_out;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
            @(negedge clk_in);
        end while (done_out !== 1'h1 && ill !== 1'h1 && k < 40);
        q.delete();
        @(posedge clk_in);
        #1;
    endtask
    task automatic rnd();
        {opsize32_in, addrsize32_in} = $random(seed);
        acc_in = $random(seed);
        reg_a_in = $random(seed);
        reg_b_in = $random(seed);
        flags_in = $random(seed);
        v = $random(seed);
    endtask
    function automatic logic [37:0] alu(input logic [31:0] a, input logic [31:0] b, input logic c, input int wb);
        logic [32:0] sm;
        logic [31:0] r;
        logic [31:0] mk;
        mk = 32'hFFFFFFFF >> (32 - wb);
        sm = {1'h0, a & mk} + {1'h0, b & mk} + 33'(c);
        r = sm[31:0] & mk;
        return {a[wb-1] == b[wb-1] && r[wb-1] != a[wb-1], r[wb-1], r == 32'h0, a[4] ^ b[4] ^ r[4], ~^r[7:0], sm[wb], r};
    endfunction
    function automatic logic [21:0] adj(input int j, input logic [15:0] ax, input logic [5:0] f);
        logic [7:0] al;
        logic [7:0] ah;
        logic       hit;
        al = ax[7:0];
        ah = ax[15:8];
        hit = al[3:0] > 4'h9 || f[aad_pkg::FLG_AF];
        if (j == 0 || j == 3) begin
            al = (hit ? ((j == 0) ? al + 8'h06 : al - 8'h06) : al) & 8'h0F;
            ah = (j == 0) ? ah + 8'(hit) : ah - 8'(hit);
            f[aad_pkg::FLG_AF] = hit;
            f[aad_pkg::FLG_CF] = hit;
        end else begin
            {ah, al} = (j == 1) ? {8'h00, 8'(al + ah * 8'h0A)} : {8'(al / 8'h0A), 8'(al % 8'h0A)};
            f[aad_pkg::FLG_SF] = al[7];
            f[aad_pkg::FLG_ZF] = al == 8'h00;
            f[aad_pkg::FLG_PF] = ~^al;
        end
        return {f, ah, al};
    endfunction
    initial begin
        {byte_valid_in, byte_in, reset_n_in} = '0;
        rnd();
        repeat (5) @(posedge clk_in);
        #1 reset_n_in = 1'h1;
        for (int i = 0; i < 30; i++) begin
            rnd();
            {adc, d, w} = $random(seed);
            n = i % 3;
            q = '{{3'h0, adc, 2'h0, d, w}, {(n == 0) ? aad_pkg::MOD_REG : 2'(n), reg_a_in[2:0], 3'h1}};
            for (int j = 0; j < ((n == 2) ? (addrsize32_in ? 4 : 2) : n); j++) q.push_back(v[8*j +: 8]);
            run();
            wd = w ? (opsize32_in ? 32 : 16) : 8;
            ex = alu(reg_a_in, reg_b_in, adc & flags_in[aad_pkg::FLG_CF], wd);
            check("add_latency", 32'(k), 32'h1);
            check("add_legal", 32'(ill), 32'h0);
            check("mem_form", 32'(dec_out.mem), 32'(n != 0));
            check("add_result", result_out & (32'hFFFFFFFF >> (32 - wd)), ex[31:0]);
            check("add_flags", 32'(flags_out), 32'(ex[37:32]));
            check("dir_wide", 32'({dec_out.dir, dec_out.wide}), 32'({d, w}));
            m = (n == 2 && !addrsize32_in) ? 32'hFFFF : 32'hFFFFFFFF;
            if (n > 0) check("disp", dec_out.disp & m, (n == 1) ? {{24{v[7]}}, v[7:0]} : v & m);
        end
        $display("Test add_forms finished");
        for (int i = 0; i < 24; i++) begin
            rnd();
            {adc, g, s, w} = $random(seed);
            s = s & w & g;
            q.push_back(g ? {6'h20, s, w} : {3'h0, adc, 3'h2, w});
            if (g) q.push_back({aad_pkg::MOD_REG, adc ? aad_pkg::REG_ADC : aad_pkg::REG_ADD, reg_b_in[2:0]});
            wd = w ? (opsize32_in ? 32 : 16) : 8;
            n = (!w || s) ? 1 : wd / 8;
            for (int j = 0; j < n; j++) q.push_back(v[8*j +: 8]);
            run();
            v = s ? {{24{v[7]}}, v[7:0]} : v & (32'hFFFFFFFF >> (32 - 8 * n));
            ex = alu(g ? reg_b_in : acc_in, v, adc & flags_in[aad_pkg::FLG_CF], wd);
            check("imm_latency", 32'(k), 32'h1);
            check("imm_result", result_out & (32'hFFFFFFFF >> (32 - wd)), ex[31:0]);
            check("imm_flags", 32'(flags_out), 32'(ex[37:32]));
        end
        $display("Test immediates finished");
        for (int i = 0; i < 8; i++) begin
            rnd();
            acc_in[7:6] = 2'h1;
            q.push_back(ops[i % 4]);
            if (i % 4 == 1 || i % 4 == 2) q.push_back(aad_pkg::OP_ADJ_BASE);
            run();
            ea = adj(i % 4, acc_in[15:0], flags_in);
            check("adj_latency", 32'(k), 32'(lats[i % 4]));
            check("adj_result", 32'(result_out[15:0]), 32'(ea[15:0]));
            check("adj_flags", 32'(flags_out), 32'(ea[21:16]));
        end
        $display("Test adjusts finished");
        foreach (bad[i]) begin
            q.push_back(bad[i][15:8]);
            if (bad[i][7:0] != 8'h00) q.push_back(bad[i][7:0]);
            run();
            check("illegal", 32'(ill), 32'h1);
        end
        // Reset in mid-execution must drop the pending result
        send(aad_pkg::OP_ADJ_MUL);
        send(aad_pkg::OP_ADJ_BASE);
        byte_valid_in = 1'h0;
        repeat (4) @(posedge clk_in);
        #1 reset_n_in = 1'h0;
        #1 check("in_reset", 32'({flags_out, done_out, byte_ready_out}), 32'h0);
        repeat (2) @(posedge clk_in);
        #1 reset_n_in = 1'h1;
        q.push_back(aad_pkg::OP_ADJ_SUM);
        run();
        check("restart", 32'(k), 32'h3);
        $display("Test refusals and reset finished");
        final_report();
    end
endmodule // aad_core_tb
